//--- include/ppm_pkg.sv
// constants and helpers for the port pin function multiplexer
package ppm_pkg;
  // register word select, address bits [4:2]
  localparam logic [2:0] R_IN = 3'h0;
  localparam logic [2:0] R_OUT = 3'h1;
  localparam logic [2:0] R_DIR = 3'h2;
  localparam logic [2:0] R_IFG = 3'h3;
  localparam logic [2:0] R_IES = 3'h4;
  localparam logic [2:0] R_IE = 3'h5;
  localparam logic [2:0] R_SEL = 3'h6;
  localparam logic [2:0] R_IFS = 3'h7;
  // byte addresses of the register groups
  localparam logic [7:0] A_P1 = 8'h00;
  localparam logic [7:0] A_P2 = 8'h20;
  localparam logic [7:0] A_CFG = 8'h40;
  // config word fields
  localparam int C_MODE = 0;
  localparam int C_PSEL = 8;
  localparam int C_SVS = 12;
  localparam int C_USEPS = 16;
  // thresholds and codes
  localparam logic [7:0] THR_MODE_HI = 8'hE0;
  localparam logic [7:0] THR_MODE_LO = 8'hC0;
  localparam logic [3:0] THR_PS_A = 4'h5;
  localparam logic [3:0] THR_PS_B = 4'h4;
  localparam logic [3:0] SVS_ANALOG = 4'hF;
  localparam logic [7:0] P1_MASK = 8'hFC;
  localparam logic [7:0] P2_MASK = 8'hFF;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // address maps onto a register
  function automatic logic addr_ok(input logic [7:0] a);
    return (a[7:5] == A_P1[7:5]) || (a[7:5] == A_P2[7:5]) || (a[7:2] == A_CFG[7:2]);
  endfunction

  // pin group carries segment drive
  function automatic logic seg_on(input logic [7:0] mode, input logic [3:0] psel,
                                  input logic use_ps, input logic [7:0] mthr,
                                  input logic [3:0] pthr);
    return use_ps ? (psel >= pthr) : (mode >= mthr);
  endfunction
endpackage

//--- core/ppm_sync.sv
// three-stage pin input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module ppm_sync #(
  parameter int W = 6
) (
  input wire logic clk, // system clock
  input wire logic nrst, // async reset, low
  input wire logic [W-1:0] d, // raw pin levels
  output logic [W-1:0] q // filtered levels
);
  typedef struct packed {
    logic [W-1:0] f1;
    logic [W-1:0] f2;
    logic [W-1:0] f3;
    logic [W-1:0] q;
  } ppm_sync_t;
  ppm_sync_t s;
  ppm_sync_t next_s;

  // shift chain, accept a bit once stages two and three agree
  always_comb begin
    next_s = s;
    next_s.f1 = d;
    next_s.f2 = s.f1;
    next_s.f3 = s.f2;
    next_s.q = (s.f2 & s.f3) | (s.q & (s.f2 ^ s.f3));
  end

  // state register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  assign q = s.q;
endmodule
`default_nettype wire

//--- core/ppm_axil.sv
// axi4-lite slave front end for the pin mux registers
`timescale 1ns/1ps
`default_nettype none
module ppm_axil (
  input wire logic clk, // system clock
  input wire logic nrst, // async reset, low
  input wire logic [7:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // byte enables
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // response valid
  input wire logic bready, // response ready
  input wire logic [7:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read valid
  input wire logic rready, // read ready
  output logic wr_en, // register write strobe
  output logic [7:0] wr_addr, // write address
  output logic [31:0] wr_data, // write data
  output logic [3:0] wr_strb, // write byte enables
  output logic [7:0] rd_addr, // read address
  input wire logic [31:0] rd_data // read mux result
);
  typedef struct packed {
    logic aw_full;
    logic [7:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_pend;
    logic [7:0] ar_addr;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ppm_axil_t;
  ppm_axil_t s;
  ppm_axil_t next_s;
  logic fire;

  // write fires once address and data are both held and no write response is pending
  assign fire = s.aw_full && s.w_full && !s.bvalid;

  // channel handshakes
  always_comb begin
    next_s = s;
    if (awvalid && s.awready) begin
      next_s.aw_full = 1'h1;
      next_s.aw_addr = awaddr;
    end
    if (wvalid && s.wready) begin
      next_s.w_full = 1'h1;
      next_s.w_data = wdata;
      next_s.w_strb = wstrb;
    end
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'h0;
    end
    if (fire) begin
      next_s.aw_full = 1'h0;
      next_s.w_full = 1'h0;
      next_s.bvalid = 1'h1;
      next_s.bresp = ppm_pkg::addr_ok(s.aw_addr) ? ppm_pkg::RESP_OKAY : ppm_pkg::RESP_SLVERR;
    end
    next_s.awready = !next_s.aw_full;
    next_s.wready = !next_s.w_full;
    if (s.rvalid && rready) begin
      next_s.rvalid = 1'h0;
    end
    if (arvalid && s.arready) begin
      next_s.ar_pend = 1'h1;
      next_s.ar_addr = araddr;
    end
    if (s.ar_pend) begin
      next_s.ar_pend = 1'h0;
      next_s.rvalid = 1'h1;
      next_s.rdata = rd_data;
      next_s.rresp = ppm_pkg::addr_ok(s.ar_addr) ? ppm_pkg::RESP_OKAY : ppm_pkg::RESP_SLVERR;
    end
    next_s.arready = !next_s.ar_pend && !next_s.rvalid;
  end

  // state register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // outputs
  assign awready = s.awready;
  assign wready = s.wready;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = s.arready;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  assign wr_en = fire;
  assign wr_addr = s.aw_addr;
  assign wr_data = s.w_data;
  assign wr_strb = s.w_strb;
  assign rd_addr = s.ar_addr;
endmodule
`default_nettype wire

//--- core/ppm_top.sv
// pin function multiplexer for first-port bits 2-7 and second port
`timescale 1ns/1ps
`default_nettype none
module ppm_top (
  input wire logic CLOCK, // 20 MHz system clock
  input wire logic NRST, // async reset, low
  input wire logic [7:0] AWADDR, // axi write address
  input wire logic AWVALID, // axi
  output logic AWREADY, // axi
  input wire logic [31:0] WDATA, // axi write data
  input wire logic [3:0] WSTRB, // axi byte enables
  input wire logic WVALID, // axi
  output logic WREADY, // axi
  output logic [1:0] BRESP, // axi
  output logic BVALID, // axi
  input wire logic BREADY, // axi
  input wire logic [7:0] ARADDR, // axi read address
  input wire logic ARVALID, // axi
  output logic ARREADY, // axi
  output logic [31:0] RDATA, // axi
  output logic [1:0] RRESP, // axi
  output logic RVALID, // axi
  input wire logic RREADY, // axi
  input wire logic [5:0] P1_IN, // pin levels, bits 7..2
  output logic [5:0] P1_OUT, // pin drive value
  output logic [5:0] P1_OE, // pin drive enable
  output logic [5:0] P1_SEG_EN, // pin carries segment S26..S31
  input wire logic [5:0] P2_IN, // pin levels, bits 5..0
  output logic [5:0] P2_OUT, // pin drive value
  output logic [5:0] P2_OE, // pin drive enable
  output logic [1:0] P2_SEG_EN, // pin carries segment S24,S25
  output logic P2_ANALOG_EN, // bit 3 routed to supervisor
  input wire logic TIMER_OUT1, // timer unit 1 output
  input wire logic TIMER_OUT2, // timer unit 2 output
  input wire logic SUPERVISOR_OUT, // supervisor output
  input wire logic ACLK_IN, // auxiliary clock level
  input wire logic SERIAL_MOSI_OUT, // serial mosi drive
  input wire logic SERIAL_MOSI_DIR, // serial mosi direction
  input wire logic SERIAL_MISO_OUT, // serial miso drive
  input wire logic SERIAL_MISO_DIR, // serial miso direction
  input wire logic SERIAL_CLK_OUT, // serial clock drive
  input wire logic SERIAL_CLK_DIR, // serial clock direction
  input wire logic ASYNC_TX, // async transmit data
  output logic TIMER_CAP_1A, // capture input 1A
  output logic TIMER_CAP_2A, // capture input 2A
  output logic TIMER_EXT_CLK, // timer external clock
  output logic SERIAL_MOSI_IN, // serial mosi receive
  output logic SERIAL_MISO_IN, // serial miso receive
  output logic SERIAL_CLK_IN, // serial clock receive
  output logic SERIAL_STE_IN, // slave transmit enable
  output logic ASYNC_RX, // async receive data
  output logic IRQ // level, unmasked flag set
);
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] dir;
    logic [7:0] ifg;
    logic [7:0] ies;
    logic [7:0] ie;
    logic [7:0] sel;
  } ppm_port_t;

  typedef struct packed {
    ppm_port_t p1;
    ppm_port_t p2;
    logic [7:0] prev1;
    logic [7:0] prev2;
    logic [7:0] mode;
    logic [3:0] psel;
    logic [3:0] svs;
    logic use_ps;
    logic [5:0] o1;
    logic [5:0] oe1;
    logic [5:0] seg1;
    logic [5:0] o2;
    logic [5:0] oe2;
    logic [1:0] seg2;
    logic ana;
    logic [7:0] mod_in;
    logic irq;
  } ppm_state_t;

  ppm_state_t st;
  ppm_state_t next_st;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic [5:0] s1;
  logic [5:0] s2;
  logic seg_a, seg_b, seg_c, ana;
  logic [7:0] segm1, segm2, in1, in2, ev1, ev2, mo1, md1, mo2, md2, po1, pd1, po2, pd2;

  // bitwise choice between module and port values
  function automatic logic [7:0] pmux(input logic [7:0] s, input logic [7:0] a,
                                      input logic [7:0] b);
    return (s & a) | (~s & b);
  endfunction

  // edge per select: 0 rising, 1 falling
  function automatic logic [7:0] edge_of(input logic [7:0] v, input logic [7:0] p,
                                         input logic [7:0] ies);
    return (v ^ p) & (v ^ ies);
  endfunction

  // register write and flag update; hardware set wins over clear
  function automatic ppm_port_t port_wr(input ppm_port_t p, input logic en,
                                        input logic [2:0] r, input logic [7:0] d,
                                        input logic [7:0] m, input logic [7:0] ev);
    ppm_port_t q;
    q = p;
    if (en) begin
      case (r)
        ppm_pkg::R_OUT: q.out = d & m;
        ppm_pkg::R_DIR: q.dir = d & m;
        ppm_pkg::R_IFG: q.ifg = p.ifg & ~d;
        ppm_pkg::R_IES: q.ies = d & m;
        ppm_pkg::R_IE: q.ie = d & m;
        ppm_pkg::R_SEL: q.sel = d & m;
        ppm_pkg::R_IFS: q.ifg = p.ifg | (d & m);
        default: q = p;
      endcase
    end
    q.ifg = q.ifg | (ev & m);
    return q;
  endfunction

  // register read view
  function automatic logic [7:0] port_rd(input ppm_port_t p, input logic [2:0] r,
                                         input logic [7:0] v);
    case (r)
      ppm_pkg::R_IN: return v;
      ppm_pkg::R_OUT: return p.out;
      ppm_pkg::R_DIR: return p.dir;
      ppm_pkg::R_IES: return p.ies;
      ppm_pkg::R_IE: return p.ie;
      ppm_pkg::R_SEL: return p.sel;
      default: return p.ifg;
    endcase
  endfunction

  // bus slave
  ppm_axil u_axil (
    .clk(CLOCK), .nrst(NRST),
    .awaddr(AWADDR), .awvalid(AWVALID), .awready(AWREADY),
    .wdata(WDATA), .wstrb(WSTRB), .wvalid(WVALID), .wready(WREADY),
    .bresp(BRESP), .bvalid(BVALID), .bready(BREADY),
    .araddr(ARADDR), .arvalid(ARVALID), .arready(ARREADY),
    .rdata(RDATA), .rresp(RRESP), .rvalid(RVALID), .rready(RREADY),
    .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .wr_strb(wr_strb),
    .rd_addr(rd_addr), .rd_data(rd_data)
  );

  // pin input synchronisers
  ppm_sync #(.W(6)) u_sync1 (.clk(CLOCK), .nrst(NRST), .d(P1_IN), .q(s1));
  ppm_sync #(.W(6)) u_sync2 (.clk(CLOCK), .nrst(NRST), .d(P2_IN), .q(s2));

  // segment and analog selection, input gating, edge events
  always_comb begin
    seg_a = ppm_pkg::seg_on(st.mode, st.psel, st.use_ps, ppm_pkg::THR_MODE_HI,
                            ppm_pkg::THR_PS_A);
    seg_b = ppm_pkg::seg_on(st.mode, st.psel, st.use_ps, ppm_pkg::THR_MODE_LO,
                            ppm_pkg::THR_PS_B);
    seg_c = ppm_pkg::seg_on(st.mode, st.psel, st.use_ps, ppm_pkg::THR_MODE_HI,
                            ppm_pkg::THR_PS_B);
    ana = (st.svs == ppm_pkg::SVS_ANALOG);
    segm1 = {{2{seg_b}}, {4{seg_a}}, 2'h0};
    segm2 = {4'h0, ana, 1'h0, {2{seg_c}}};
    in1 = {s1, 2'h0} & ~segm1;
    in2 = {2'h0, s2} & ~segm2;
    ev1 = edge_of(in1, st.prev1, st.p1.ies);
    ev2 = edge_of(in2, st.prev2, st.p2.ies);
    mo1 = {SERIAL_MISO_OUT, SERIAL_MOSI_OUT, ACLK_IN, 1'h0, SUPERVISOR_OUT,
           TIMER_OUT1, 2'h0};
    md1 = {SERIAL_MISO_DIR, SERIAL_MOSI_DIR, st.p1.dir[5:2], 2'h0};
    mo2 = {3'h0, ASYNC_TX, 2'h0, SERIAL_CLK_OUT, TIMER_OUT2};
    md2 = {3'h0, 1'h1, st.p2.dir[3], 1'h0, SERIAL_CLK_DIR, st.p2.dir[0]};
    // pin drive and enable chosen per select bit
    po1 = pmux(st.p1.sel, mo1, st.p1.out);
    pd1 = pmux(st.p1.sel, md1, st.p1.dir);
    po2 = pmux(st.p2.sel, mo2, st.p2.out);
    pd2 = pmux(st.p2.sel, md2, st.p2.dir);
  end

  // read mux
  always_comb begin
    rd_data = 32'h0;
    if (rd_addr[7:5] == ppm_pkg::A_P1[7:5]) begin
      rd_data[7:0] = port_rd(st.p1, rd_addr[4:2], in1);
    end else if (rd_addr[7:5] == ppm_pkg::A_P2[7:5]) begin
      rd_data[7:0] = port_rd(st.p2, rd_addr[4:2], in2);
    end else if (rd_addr[7:2] == ppm_pkg::A_CFG[7:2]) begin
      rd_data[ppm_pkg::C_MODE +: 8] = st.mode;
      rd_data[ppm_pkg::C_PSEL +: 4] = st.psel;
      rd_data[ppm_pkg::C_SVS +: 4] = st.svs;
      rd_data[ppm_pkg::C_USEPS] = st.use_ps;
    end
  end

  // next state: registers, flags, pin and module outputs
  always_comb begin
    next_st = st;
    next_st.p1 = port_wr(st.p1, wr_en && wr_strb[0] && wr_addr[7:5] == ppm_pkg::A_P1[7:5],
                         wr_addr[4:2], wr_data[7:0], ppm_pkg::P1_MASK, ev1);
    next_st.p2 = port_wr(st.p2, wr_en && wr_strb[0] && wr_addr[7:5] == ppm_pkg::A_P2[7:5],
                         wr_addr[4:2], wr_data[7:0], ppm_pkg::P2_MASK, ev2);
    if (wr_en && wr_addr[7:2] == ppm_pkg::A_CFG[7:2]) begin
      if (wr_strb[0]) begin
        next_st.mode = wr_data[ppm_pkg::C_MODE +: 8];
      end
      if (wr_strb[1]) begin
        next_st.psel = wr_data[ppm_pkg::C_PSEL +: 4];
        next_st.svs = wr_data[ppm_pkg::C_SVS +: 4];
      end
      if (wr_strb[2]) begin
        next_st.use_ps = wr_data[ppm_pkg::C_USEPS];
      end
    end
    next_st.prev1 = in1;
    next_st.prev2 = in2;
    next_st.o1 = po1[7:2] & ~segm1[7:2];
    next_st.oe1 = pd1[7:2] & ~segm1[7:2];
    next_st.seg1 = segm1[7:2];
    next_st.o2 = po2[5:0] & ~segm2[5:0];
    next_st.oe2 = pd2[5:0] & ~segm2[5:0];
    next_st.seg2 = segm2[1:0];
    next_st.ana = ana;
    next_st.mod_in = {in2[5], in2[2], in2[1], in2[0], in1[7], in1[6], in1[5], in1[2]};
    next_st.irq = |(st.p1.ifg & st.p1.ie) | |(st.p2.ifg & st.p2.ie);
  end

  // state register
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // outputs
  assign P1_OUT = st.o1;
  assign P1_OE = st.oe1;
  assign P1_SEG_EN = st.seg1;
  assign P2_OUT = st.o2;
  assign P2_OE = st.oe2;
  assign P2_SEG_EN = st.seg2;
  assign P2_ANALOG_EN = st.ana;
  assign TIMER_CAP_1A = st.mod_in[0];
  assign TIMER_EXT_CLK = st.mod_in[1];
  assign SERIAL_MOSI_IN = st.mod_in[2];
  assign SERIAL_MISO_IN = st.mod_in[3];
  assign TIMER_CAP_2A = st.mod_in[4];
  assign SERIAL_CLK_IN = st.mod_in[5];
  assign SERIAL_STE_IN = st.mod_in[6];
  assign ASYNC_RX = st.mod_in[7];
  assign IRQ = st.irq;

  // checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);

  property p_seg_no_drive;
    ((P1_SEG_EN & P1_OE) == 6'h0) && ((P2_SEG_EN & P2_OE[1:0]) == 2'h0);
  endproperty
  a_seg_no_drive: assert property (p_seg_no_drive) else $error("segment pin driven");

  property p_grp_b;
    (!st.use_ps && st.mode >= ppm_pkg::THR_MODE_LO) |=> P1_SEG_EN[5:4] == 2'h3;
  endproperty
  a_grp_b: assert property (p_grp_b) else $error("bits 6,7 not on segments");

  property p_grp_c;
    (!st.use_ps && st.mode < ppm_pkg::THR_MODE_HI) |=> P2_SEG_EN == 2'h0;
  endproperty
  a_grp_c: assert property (p_grp_c) else $error("bits 0,1 left port function");

  property p_sclk;
    (st.p2.sel[1] && !seg_c) |=> (P2_OUT[1] == $past(SERIAL_CLK_OUT))
      && (P2_OE[1] == $past(SERIAL_CLK_DIR));
  endproperty
  a_sclk: assert property (p_sclk) else $error("serial clock not on pin");

  property p_cap1a;
    !seg_a |=> TIMER_CAP_1A == $past(s1[0]);
  endproperty
  a_cap1a: assert property (p_cap1a) else $error("capture 1A not fed");

  property p_analog;
    (st.svs == ppm_pkg::SVS_ANALOG) |-> !in2[3] ##1 (P2_ANALOG_EN && !P2_OE[3]);
  endproperty
  a_analog: assert property (p_analog) else $error("analog bit not isolated");

  property p_dir_forced;
    (st.p2.sel[4] |=> P2_OE[4]) and (st.p2.sel[5] |=> !P2_OE[5]);
  endproperty
  a_dir_forced: assert property (p_dir_forced) else $error("forced direction wrong");

  property p_ste_in;
    st.p2.sel[2] |=> !P2_OE[2];
  endproperty
  a_ste_in: assert property (p_ste_in) else $error("bit 2 not an input");

  property p_soft_flags;
    !wr_en |=> $stable(st.p2.ifg[7:6]);
  endproperty
  a_soft_flags: assert property (p_soft_flags) else $error("unbonded flag moved");

  property p_edge_flag;
    (ev1 != 8'h0) |=> (st.p1.ifg & $past(ev1)) == $past(ev1);
  endproperty
  a_edge_flag: assert property (p_edge_flag) else $error("edge flag lost");

  c_seg: cover property (!P1_SEG_EN[0] ##1 P1_SEG_EN[0]);
  c_irq: cover property (!IRQ ##1 IRQ);
  c_tx: cover property (st.p2.sel[4] ##1 P2_OE[4]);
endmodule
`default_nettype wire

//--- bench/ppm_board.sv
// board side model that resolves each pin level from the device drive
`timescale 1ns/1ps
`default_nettype none
module ppm_board (
  input wire logic [5:0] p1_out, // device drive value
  input wire logic [5:0] p1_oe, // device drive enable
  input wire logic [5:0] p1_ext, // weak board source
  input wire logic [5:0] p2_out, // device drive value
  input wire logic [5:0] p2_oe, // device drive enable
  input wire logic [5:0] p2_ext, // weak board source
  output logic [5:0] p1_pin, // resolved level
  output logic [5:0] p2_pin // resolved level
);
  // a driving device overrides the board source bit by bit
  assign p1_pin = (p1_oe & p1_out) | (~p1_oe & p1_ext);
  assign p2_pin = (p2_oe & p2_out) | (~p2_oe & p2_ext);
endmodule
`default_nettype wire

//--- bench/tb.sv
// self-checking bench for the pin function multiplexer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, v) begin \
  total_checks++; \
  if ((v) !== (e)) begin \
    num_errors++; \
    $display("wrong value %s exp %0h got %0h", nm, e, v); \
  end \
end
module tb;
  logic CLOCK = 0, NRST = 0, AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
  logic [7:0] AWADDR = 0, ARADDR = 0;
  logic [31:0] WDATA = 0, RDATA, x, d, o;
  logic [3:0] WSTRB = 0;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, P2_ANALOG_EN, IRQ;
  logic [1:0] BRESP, RRESP, P2_SEG_EN, r;
  logic [5:0] P1_IN, P1_OUT, P1_OE, P1_SEG_EN, P2_IN, P2_OUT, P2_OE, p1_ext = 0, p2_ext = 0;
  logic TIMER_OUT1 = 0, TIMER_OUT2 = 0, SUPERVISOR_OUT = 0, ACLK_IN = 0, ASYNC_TX = 0;
  logic SERIAL_MOSI_OUT = 0, SERIAL_MOSI_DIR = 0, SERIAL_MISO_OUT = 0, SERIAL_MISO_DIR = 0;
  logic SERIAL_CLK_OUT = 0, SERIAL_CLK_DIR = 0;
  logic TIMER_CAP_1A, TIMER_CAP_2A, TIMER_EXT_CLK, SERIAL_MOSI_IN, SERIAL_MISO_IN;
  logic SERIAL_CLK_IN, SERIAL_STE_IN, ASYNC_RX;
  int num_errors = 0, total_checks = 0;
  logic [31:0] cfg [8] = '{32'h000000BF, 32'h000000C0, 32'h000000DF, 32'h0000F0E0,
                           32'h000103FF, 32'h00010400, 32'h00010500, 32'h0000E000};

  ppm_top i_dut (.CLOCK, .NRST, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID,
    .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID,
    .RREADY, .P1_IN, .P1_OUT, .P1_OE, .P1_SEG_EN, .P2_IN, .P2_OUT, .P2_OE, .P2_SEG_EN,
    .P2_ANALOG_EN, .TIMER_OUT1, .TIMER_OUT2, .SUPERVISOR_OUT, .ACLK_IN, .SERIAL_MOSI_OUT,
    .SERIAL_MOSI_DIR, .SERIAL_MISO_OUT, .SERIAL_MISO_DIR, .SERIAL_CLK_OUT, .SERIAL_CLK_DIR,
    .ASYNC_TX, .TIMER_CAP_1A, .TIMER_CAP_2A, .TIMER_EXT_CLK, .SERIAL_MOSI_IN,
    .SERIAL_MISO_IN, .SERIAL_CLK_IN, .SERIAL_STE_IN, .ASYNC_RX, .IRQ);
  ppm_board i_board (.p1_out(P1_OUT), .p1_oe(P1_OE), .p1_ext(p1_ext), .p2_out(P2_OUT),
    .p2_oe(P2_OE), .p2_ext(p2_ext), .p1_pin(P1_IN), .p2_pin(P2_IN));

  // free running system clock
  always #25 CLOCK = ~CLOCK;

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic tmo();
    num_errors++;
    report_and_stop();
  endtask
  function automatic logic [31:0] xs();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction
  // expected segment enables {p2 s24 s25, p1 s26..s31}
  function automatic logic [7:0] seg(input logic [31:0] c);
    logic a, b, e;
    a = c[16] ? c[11:8] >= 4'h5 : c[7:0] >= 8'hE0;
    b = c[16] ? c[11:8] >= 4'h4 : c[7:0] >= 8'hC0;
    e = c[16] ? c[11:8] >= 4'h4 : c[7:0] >= 8'hE0;
    return {{2{e}}, {2{b}}, {4{a}}};
  endfunction
  task automatic settle(input int n);
    repeat (n) @(posedge CLOCK);
  endtask
  // one write, address and data offered together
  task automatic axw(input logic [7:0] a, input logic [31:0] dv, output logic [1:0] rs);
    int n;
    n = 0;
    AWADDR <= a;
    WDATA <= dv;
    WSTRB <= 4'hF;
    AWVALID <= 1;
    WVALID <= 1;
    BREADY <= 1;
    do begin
      @(posedge CLOCK);
      if (AWREADY) AWVALID <= 0;
      if (WREADY) WVALID <= 0;
      if (++n > 60) tmo();
    end while (!BVALID);
    rs = BRESP;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] rs);
    int n;
    n = 0;
    ARADDR <= a;
    ARVALID <= 1;
    RREADY <= 1;
    do begin
      @(posedge CLOCK);
      if (ARREADY) ARVALID <= 0;
      if (++n > 60) tmo();
    end while (!RVALID);
    dv = RDATA;
    rs = RRESP;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dv);
    logic [1:0] rs;
    axw(a, dv, rs);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] dv;
    logic [1:0] rs;
    axr(a, dv, rs);
    `CHK(nm, e, dv)
    `CHK("rresp", 2'h0, rs)
  endtask
  // random peripheral levels and board pin sources
  task automatic rnd();
    o = xs();
    {TIMER_OUT1, TIMER_OUT2, SUPERVISOR_OUT, ACLK_IN, ASYNC_TX, SERIAL_MOSI_OUT} <= o[5:0];
    {SERIAL_MOSI_DIR, SERIAL_MISO_OUT, SERIAL_MISO_DIR, SERIAL_CLK_OUT} <= o[9:6];
    SERIAL_CLK_DIR <= o[10];
    p1_ext <= o[16:11];
    p2_ext <= o[22:17];
  endtask

  // main sequence
  initial begin
    x = 47;
    repeat (4) @(posedge CLOCK);
    NRST <= 1;
    @(posedge CLOCK);
    rdc(8'h18, 32'h0, "p1 sel reset");
    rdc(8'h3C, 32'h0, "p2 flags reset");
    axr(8'h60, d, r);
    `CHK("unmapped rresp", 2'h2, r)
    axw(8'h60, 32'hFF, r);
    `CHK("unmapped bresp", 2'h2, r)
    $display("test reset done");
    wr(8'h08, 32'hFC);
    d = xs();
    wr(8'h04, d);
    settle(3);
    `CHK("p1 oe", 6'h3F, P1_OE)
    `CHK("p1 out", d[7:2], P1_OUT)
    wr(8'h08, 32'h0);
    rnd();
    settle(7);
    rdc(8'h00, {24'h0, p1_ext, 2'h0}, "p1 in");
    $display("test gpio done");
    wr(8'h18, 32'hFC);
    wr(8'h38, 32'h3F);
    repeat (8) begin
      rnd();
      settle(7);
      `CHK("cap 1a", p1_ext[0], TIMER_CAP_1A)
      `CHK("tout1", TIMER_OUT1, P1_OUT[0])
      `CHK("ext clk", p1_ext[3], TIMER_EXT_CLK)
      `CHK("aclk", ACLK_IN, P1_OUT[3])
      `CHK("miso oe", SERIAL_MISO_DIR, P1_OE[5])
      `CHK("miso in", SERIAL_MISO_DIR ? SERIAL_MISO_OUT : p1_ext[5], SERIAL_MISO_IN)
      `CHK("mosi oe", SERIAL_MOSI_DIR, P1_OE[4])
      `CHK("mosi in", SERIAL_MOSI_DIR ? SERIAL_MOSI_OUT : p1_ext[4], SERIAL_MOSI_IN)
      `CHK("svs out", SUPERVISOR_OUT, P1_OUT[1])
      `CHK("cap 2a", p2_ext[0], TIMER_CAP_2A)
      `CHK("tout2", TIMER_OUT2, P2_OUT[0])
      `CHK("clk out", SERIAL_CLK_OUT, P2_OUT[1])
      `CHK("clk in", SERIAL_CLK_DIR ? SERIAL_CLK_OUT : p2_ext[1], SERIAL_CLK_IN)
      `CHK("tx", {1'b1, ASYNC_TX}, {P2_OE[4], P2_OUT[4]})
      `CHK("rx", {1'b0, p2_ext[5]}, {P2_OE[5], ASYNC_RX})
      `CHK("ste", {1'b0, p2_ext[2]}, {P2_OE[2], SERIAL_STE_IN})
    end
    $display("test peripheral done");
    for (int i = 0; i < 8; i++) begin
      wr(8'h40, cfg[i]);
      settle(3);
      `CHK("seg", seg(cfg[i]), {P2_SEG_EN, P1_SEG_EN})
      `CHK("analog", cfg[i][15:12] == 4'hF, P2_ANALOG_EN)
    end
    $display("test segment done");
    wr(8'h40, 32'h0);
    settle(8);
    wr(8'h2C, 32'hFF);
    wr(8'h3C, 32'hC0);
    rdc(8'h2C, 32'hC0, "soft flags");
    `CHK("irq masked", 1'b0, IRQ)
    wr(8'h34, 32'h40);
    settle(2);
    `CHK("irq on", 1'b1, IRQ)
    wr(8'h2C, 32'h40);
    settle(2);
    `CHK("irq off", 1'b0, IRQ)
    rdc(8'h2C, 32'h80, "flag left");
    wr(8'h24, 32'hC0);
    rdc(8'h24, 32'hC0, "p2 out hi");
    wr(8'h18, 32'h0);
    p1_ext <= 6'h00;
    settle(8);
    wr(8'h0C, 32'hFF);
    p1_ext <= 6'h02;
    settle(8);
    rdc(8'h0C, 32'h08, "p1 edge");
    wr(8'h14, 32'h08);
    settle(2);
    `CHK("irq p1", 1'b1, IRQ)
    $display("test interrupt done");
    report_and_stop();
  end
endmodule
`default_nettype wire
